// File: shared/fault_pkg.sv
// Constants, types and register map of the motor starter fault handler
package fault_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SECOND_S = 1;
  localparam int unsigned SECOND_CYCLES = CLK_HZ * SECOND_S;

  // Automatic reset window lengths, in minutes as set by the user
  localparam int unsigned WIN_5_MIN = 5;
  localparam int unsigned WIN_10_MIN = 10;
  localparam int unsigned WIN_30_MIN = 30;
  localparam int unsigned WIN_1_H_MIN = 60;
  localparam int unsigned WIN_2_H_MIN = 120;
  localparam int unsigned WIN_3_H_MIN = 180;
  localparam int unsigned SEC_PER_MIN = 60;

  // Register byte addresses
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_FAN_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;

  // Config register field positions
  localparam int unsigned CFG_SRC_LSB = 0;
  localparam int unsigned CFG_HIGH_BIT = 2;
  localparam int unsigned CFG_DI_LSB = 3;
  localparam int unsigned CFG_CD_LSB = 6;
  localparam int unsigned CFG_RESP_LSB = 10;
  localparam int unsigned CFG_AUTO_BIT = 13;
  localparam int unsigned CFG_WIN_LSB = 14;

  // State register field positions
  localparam int unsigned STAT_COND_BIT = 0;
  localparam int unsigned STAT_EXPIRED_BIT = 1;
  localparam int unsigned STAT_SECONDS_LSB = 2;
  localparam int unsigned STAT_FSM_LSB = 16;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_DIGITAL = 2'h1,
    SRC_VIRTUAL = 2'h2
  } ext_source_t;

  typedef enum logic [2:0] {
    RESP_IGNORE = 3'h0,
    RESP_FREEWHEEL = 3'h1,
    RESP_CONFIGURED = 3'h2,
    RESP_DECEL = 3'h3,
    RESP_BRAKE = 3'h4
  } ext_response_t;

  typedef enum logic [2:0] {
    WIN_5M = 3'h0,
    WIN_10M = 3'h1,
    WIN_30M = 3'h2,
    WIN_1H = 3'h3,
    WIN_2H = 3'h4,
    WIN_3H = 3'h5,
    WIN_UNLIMITED = 3'h6
  } reset_window_t;

  typedef enum logic [1:0] {
    STOP_CONFIGURED = 2'h0,
    STOP_DECEL = 2'h1,
    STOP_BRAKE = 2'h2
  } stop_kind_t;

  typedef struct packed {
    logic active;
    stop_kind_t kind;
  } stop_cmd_t;

  typedef struct packed {
    ext_source_t source;
    logic active_high;
    logic [2:0] di_index;
    logic [3:0] cd_index;
    ext_response_t response;
    logic auto_enable;
    reset_window_t window;
  } fault_cfg_t;

  localparam fault_cfg_t CFG_RESET = '{
    source: SRC_NONE,
    active_high: 1'b0,
    di_index: 3'h0,
    cd_index: 4'h0,
    response: RESP_FREEWHEEL,
    auto_enable: 1'b0,
    window: WIN_5M
  };

  // Interrupt event bit positions
  localparam int unsigned EV_FAULT = 0;
  localparam int unsigned EV_WARNING = 1;
  localparam int unsigned EV_AUTO_OK = 2;
  localparam int unsigned EV_EXPIRED = 3;
  localparam int unsigned EV_COUNT = 4;

  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_STOPPING = 4'b0010,
    ST_HALTED = 4'b0100,
    ST_FAULT = 4'b1000
  } fault_state_t;

endpackage

// File: design/motor_starter_fault_handler.sv
// External error, automatic fault reset and fan clear logic of the motor starter
// Operation
// - Three fan run-time clear commands, one per fan, default No.
// - External error source: unassigned by default, digital input, or command-word bit.
// - Digital source may be active high or active low.
// - Response settable only while source assigned; default freewheel with error.
// - Ignore: raise warning only and keep running.
// - Freewheel: raise error at once and remove motor drive.
// - Configured stop: stop with selected stop type, raise warning not error.
// - Deceleration: ramp down, raise error when deceleration completes.
// - Braking: dynamic brake stop, raise error when stop finishes.
// - Auto fault reset, off by default, resets once the cause has cleared.
// - Cause gone during auto reset: leave Fault and resume normal operation.
// - Fault output suppressed during auto attempts, asserted when they fail.
// - Fault relay stays closed while auto reset runs within the window.
// - Window expired: stop auto attempts, only manual reset leaves Fault.
// - Window 5, 10, 30 min, 1, 2, 3 h or unlimited; default 5 min.
// - Window setting writable only while auto reset is enabled.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
module motor_starter_fault_handler
  import fault_pkg::*;
#(
  parameter int unsigned N_DI = 6,
  parameter int unsigned N_CD = 16,
  parameter int unsigned SEC_CYCLES = fault_pkg::SECOND_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [N_DI-1:0] digital_input_n,
  input wire logic [N_CD-1:0] virtual_command_bit,
  input wire logic stop_done,
  input wire logic manual_reset,
  output logic motor_drive_enable,
  output fault_pkg::stop_cmd_t stop_request,
  output logic ext_error_fault,
  output logic ext_error_warning,
  output logic fault_state_out,
  output logic [2:0] fan_runtime_clear,
  output logic irq
);
  import fault_pkg::*;

  if (N_DI < 1 || N_DI > 8)
  begin
    $error("N_DI must be 1 to 8");
  end
  if (N_CD < 1 || N_CD > 16)
  begin
    $error("N_CD must be 1 to 16");
  end
  if (SEC_CYCLES < 1 || SEC_CYCLES >= (1 << 24))
  begin
    $error("SEC_CYCLES must be 1 to 2**24-1");
  end

  localparam logic [23:0] SEC_LAST = 24'(SEC_CYCLES - 1);

  // Unlimited has no length: the counter never runs while it is chosen
  function automatic logic [13:0] window_seconds(input reset_window_t w);
    unique case (w)
      WIN_5M: window_seconds = 14'(WIN_5_MIN * SEC_PER_MIN);
      WIN_10M: window_seconds = 14'(WIN_10_MIN * SEC_PER_MIN);
      WIN_30M: window_seconds = 14'(WIN_30_MIN * SEC_PER_MIN);
      WIN_1H: window_seconds = 14'(WIN_1_H_MIN * SEC_PER_MIN);
      WIN_2H: window_seconds = 14'(WIN_2_H_MIN * SEC_PER_MIN);
      WIN_3H: window_seconds = 14'(WIN_3_H_MIN * SEC_PER_MIN);
      default: window_seconds = 14'h0;
    endcase
  endfunction

  // Register group
  fault_cfg_t cfg;
  fault_cfg_t next_cfg;
  logic [EV_COUNT-1:0] irq_status;
  logic [EV_COUNT-1:0] next_irq_status;
  logic [EV_COUNT-1:0] irq_enable;
  logic [EV_COUNT-1:0] next_irq_enable;
  logic [2:0] next_fan_runtime_clear;
  logic [31:0] next_rdata;
  logic next_irq;

  // Control group
  fault_state_t state;
  fault_state_t next_state;
  logic [23:0] sec_count;
  logic [23:0] next_sec_count;
  logic [13:0] win_count;
  logic [13:0] next_win_count;
  logic expired;
  logic next_expired;
  logic next_motor_drive_enable;
  stop_cmd_t next_stop_request;
  logic next_ext_error_fault;
  logic next_ext_error_warning;
  logic next_fault_state_out;
  logic [EV_COUNT-1:0] events;

  logic ext_cond;
  logic di_level;
  logic auto_active;

  always_comb
  begin
    di_level = digital_input_n[cfg.di_index];
    ext_cond = 1'b0;
    unique case (cfg.source)
      SRC_DIGITAL: ext_cond = cfg.active_high ? di_level : ~di_level;
      SRC_VIRTUAL: ext_cond = virtual_command_bit[cfg.cd_index];
      default: ext_cond = 1'b0;
    endcase
  end

  assign auto_active = cfg.auto_enable && !expired;

  always_comb
  begin
    ext_source_t wsrc;
    wsrc = ext_source_t'(wdata[CFG_SRC_LSB +: 2]);
    next_cfg = cfg;
    next_irq_enable = irq_enable;
    next_fan_runtime_clear = 3'h0;
    next_irq_status = irq_status;
    next_rdata = 32'h0;
    if (wr)
    begin
      unique case (addr)
        ADDR_CONFIG:
        begin
          if (wsrc != SRC_NONE)
          begin
            next_cfg.source = wsrc;
          end
          else
          begin
            next_cfg.source = SRC_NONE;
          end
          if ({1'b0, wdata[CFG_DI_LSB +: 3]} < 4'(N_DI))
            next_cfg.di_index = wdata[CFG_DI_LSB +: 3];
          if (wdata[CFG_CD_LSB +: 4] <= 4'(N_CD - 1))
            next_cfg.cd_index = wdata[CFG_CD_LSB +: 4];
          next_cfg.active_high = wdata[CFG_HIGH_BIT];
          // A value outside the five responses is dropped, keeping the last good one
          if (wsrc != SRC_NONE && wdata[CFG_RESP_LSB +: 3] <= 3'(RESP_BRAKE))
            next_cfg.response = ext_response_t'(wdata[CFG_RESP_LSB +: 3]);
          next_cfg.auto_enable = wdata[CFG_AUTO_BIT];
          if (wdata[CFG_AUTO_BIT] && wdata[CFG_WIN_LSB +: 3] <= 3'(WIN_UNLIMITED))
            next_cfg.window = reset_window_t'(wdata[CFG_WIN_LSB +: 3]);
        end
        ADDR_FAN_CMD: next_fan_runtime_clear = wdata[2:0];
        ADDR_IRQ_CLEAR: next_irq_status = irq_status & ~wdata[EV_COUNT-1:0];
        ADDR_IRQ_ENABLE: next_irq_enable = wdata[EV_COUNT-1:0];
        default: next_cfg = cfg;
      endcase
    end
    // Set wins over a clear in the same cycle
    next_irq_status = next_irq_status | events;
    if (rd)
    begin
      unique case (addr)
        ADDR_CONFIG:
        begin
          next_rdata[CFG_SRC_LSB +: 2] = cfg.source;
          next_rdata[CFG_HIGH_BIT] = cfg.active_high;
          next_rdata[CFG_DI_LSB +: 3] = cfg.di_index;
          next_rdata[CFG_CD_LSB +: 4] = cfg.cd_index;
          next_rdata[CFG_RESP_LSB +: 3] = cfg.response;
          next_rdata[CFG_AUTO_BIT] = cfg.auto_enable;
          next_rdata[CFG_WIN_LSB +: 3] = cfg.window;
        end
        ADDR_STATE:
        begin
          // Seconds counted so far show software how much of the window is left
          next_rdata[STAT_COND_BIT] = ext_cond;
          next_rdata[STAT_EXPIRED_BIT] = expired;
          next_rdata[STAT_SECONDS_LSB +: 14] = win_count;
          next_rdata[STAT_FSM_LSB +: 4] = state;
        end
        ADDR_IRQ_STATUS: next_rdata[EV_COUNT-1:0] = irq_status;
        ADDR_IRQ_ENABLE: next_rdata[EV_COUNT-1:0] = irq_enable;
        default: next_rdata = 32'h0;
      endcase
    end
    next_irq = |(next_irq_status & next_irq_enable);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cfg <= CFG_RESET;
      irq_status <= '0;
      irq_enable <= '0;
      fan_runtime_clear <= 3'h0;
      rdata <= 32'h0;
      irq <= 1'b0;
    end
    else
    begin
      cfg <= next_cfg;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      fan_runtime_clear <= next_fan_runtime_clear;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  always_comb
  begin
    next_state = state;
    next_sec_count = sec_count;
    next_win_count = win_count;
    next_expired = expired;
    next_stop_request = stop_request;
    events = '0;
    unique case (state)
      ST_RUN:
      begin
        next_stop_request.active = 1'b0;
        if (ext_cond)
        begin
          unique case (cfg.response)
            RESP_FREEWHEEL:
            begin
              next_state = ST_FAULT;
              events[EV_FAULT] = 1'b1;
            end
            RESP_CONFIGURED:
            begin
              next_state = ST_HALTED;
              next_stop_request = '{active: 1'b1, kind: STOP_CONFIGURED};
              events[EV_WARNING] = 1'b1;
            end
            RESP_DECEL:
            begin
              next_state = ST_STOPPING;
              next_stop_request = '{active: 1'b1, kind: STOP_DECEL};
            end
            RESP_BRAKE:
            begin
              next_state = ST_STOPPING;
              next_stop_request = '{active: 1'b1, kind: STOP_BRAKE};
            end
            default: events[EV_WARNING] = !ext_error_warning;
          endcase
        end
      end
      ST_STOPPING:
      begin
        // The error waits for the motor side to report the end of the stop
        if (stop_done)
        begin
          next_state = ST_FAULT;
          next_stop_request.active = 1'b0;
          events[EV_FAULT] = 1'b1;
        end
      end
      ST_HALTED:
      begin
        if (!ext_cond)
        begin
          next_state = ST_RUN;
          next_stop_request.active = 1'b0;
        end
      end
      ST_FAULT:
      begin
        if (auto_active && cfg.window != WIN_UNLIMITED)
        begin
          next_sec_count = (sec_count == SEC_LAST) ? 24'h0 : sec_count + 24'h1;
          if (sec_count == SEC_LAST)
            next_win_count = win_count + 14'h1;
          if (sec_count == SEC_LAST && win_count + 14'h1 >= window_seconds(cfg.window))
          begin
            next_expired = 1'b1;
            events[EV_EXPIRED] = 1'b1;
          end
        end
        // A success in the expiry cycle still counts, since the cause is already gone
        if (!ext_cond && auto_active)
        begin
          next_state = ST_RUN;
          events[EV_AUTO_OK] = 1'b1;
        end
        else if (!ext_cond && manual_reset)
        begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
    if (next_state != ST_FAULT)
    begin
      next_sec_count = 24'h0;
      next_win_count = 14'h0;
      next_expired = 1'b0;
    end
    next_motor_drive_enable = (next_state != ST_FAULT);
    next_ext_error_fault = (next_state == ST_FAULT);
    next_ext_error_warning = (next_state == ST_HALTED) ||
      (next_state == ST_RUN && ext_cond && cfg.response == RESP_IGNORE);
    // Relay closed means healthy; it opens at once on a fault with auto reset off, else once auto reset has given up
    next_fault_state_out = (next_state == ST_FAULT) && !(cfg.auto_enable && !next_expired);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state <= ST_RUN;
      sec_count <= 24'h0;
      win_count <= 14'h0;
      expired <= 1'b0;
      motor_drive_enable <= 1'b0;
      stop_request <= '{active: 1'b0, kind: STOP_CONFIGURED};
      ext_error_fault <= 1'b0;
      ext_error_warning <= 1'b0;
      fault_state_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      sec_count <= next_sec_count;
      win_count <= next_win_count;
      expired <= next_expired;
      motor_drive_enable <= next_motor_drive_enable;
      stop_request <= next_stop_request;
      ext_error_fault <= next_ext_error_fault;
      ext_error_warning <= next_ext_error_warning;
      fault_state_out <= next_fault_state_out;
    end
  end

endmodule

// File: verification/motor_starter_fault_handler_properties.sv
// Port checker for the fault handler, bound to the top module
module fault_handler_checker
  import fault_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic stop_done,
  input wire logic motor_drive_enable,
  input wire fault_pkg::stop_cmd_t stop_request,
  input wire logic ext_error_fault,
  input wire logic ext_error_warning,
  input wire logic fault_state_out,
  input wire logic [2:0] fan_runtime_clear
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_fan_cause: assert property (fan_runtime_clear != 3'h0 |-> $past(wr) && $past(addr) == ADDR_FAN_CMD)
    else $error("fan clear without command");
  a_fan_once: assert property (fan_runtime_clear != 3'h0 && !(wr && addr == ADDR_FAN_CMD)
    |=> fan_runtime_clear == 3'h0)
    else $error("fan clear longer than one cycle");
  a_ignore_runs: assert property (ext_error_warning && !stop_request.active
    |-> motor_drive_enable && !ext_error_fault)
    else $error("warning without running");
  a_fault_coasts: assert property (ext_error_fault |-> !motor_drive_enable && !stop_request.active)
    else $error("drive kept in fault");
  a_config_warns: assert property (stop_request.active && stop_request.kind == STOP_CONFIGURED
    |-> !ext_error_fault && motor_drive_enable)
    else $error("configured stop raised error");
  a_error_after: assert property (stop_request.active && stop_request.kind != STOP_CONFIGURED && stop_done
    |=> ext_error_fault && !motor_drive_enable)
    else $error("no error after stop end");
  a_no_early: assert property (stop_request.active && stop_request.kind != STOP_CONFIGURED
    |-> !ext_error_fault)
    else $error("error before stop end");
  a_resume_run: assert property ($fell(ext_error_fault) |-> motor_drive_enable)
    else $error("no resume after fault");
  a_relay_fault: assert property (fault_state_out |-> ext_error_fault)
    else $error("relay without fault");
  cover property ($rose(ext_error_fault));
  cover property ($rose(fault_state_out));
  cover property (stop_done && stop_request.active);
endmodule

bind motor_starter_fault_handler fault_handler_checker chk (.sys_clk, .rst_n, .addr, .wr, .stop_done,
  .motor_drive_enable, .stop_request, .ext_error_fault, .ext_error_warning, .fault_state_out,
  .fan_runtime_clear);

// File: verification/ext_inputs_model.sv
// Model of the input wiring, command word and motor stop feedback
module ext_inputs_model
  import fault_pkg::*;
(
  input wire logic sys_clk,
  input wire logic cause,
  input wire logic active_high,
  input wire logic via_cd,
  input wire fault_pkg::stop_cmd_t stop_request,
  output logic [5:0] digital_input_n,
  output logic [15:0] virtual_command_bit,
  output logic stop_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 4'h0;
  // Input 2 carries the cause; low active idles high so a cut wire shows up
  always_comb
  begin
    digital_input_n = 6'h3b;
    digital_input_n[2] = via_cd ? !active_high : !(cause ^ active_high);
    virtual_command_bit = 16'h0;
    virtual_command_bit[5] = via_cd & cause;
  end
  // Stop takes a few cycles, as a real ramp would
  always_ff @(posedge sys_clk)
  begin
    cnt <= stop_request.active ? cnt + 4'h1 : 4'h0;
    stop_done <= stop_request.active && cnt == 4'h3;
  end
endmodule

// File: verification/motor_starter_fault_handler_bench.sv
// Self-checking bench for the fault handler
module motor_starter_fault_handler_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import fault_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [5:0] digital_input_n;
  logic [15:0] virtual_command_bit;
  logic stop_done;
  logic manual_reset = 1'b0;
  logic motor_drive_enable;
  stop_cmd_t stop_request;
  logic ext_error_fault;
  logic ext_error_warning;
  logic fault_state_out;
  logic [2:0] fan_runtime_clear;
  logic irq;
  logic cause = 1'b0;
  logic active_high = 1'b0;
  logic via_cd = 1'b0;
  int error_cnt = 0;
  int tests_run = 0;
  logic [2:0] r;
  logic f;

  always #50 sys_clk = !sys_clk;

  motor_starter_fault_handler #(.SEC_CYCLES(4)) dut (.sys_clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .digital_input_n, .virtual_command_bit, .stop_done, .manual_reset, .motor_drive_enable, .stop_request,
    .ext_error_fault, .ext_error_warning, .fault_state_out, .fan_runtime_clear, .irq);

  ext_inputs_model far (.sys_clk, .cause, .active_high, .via_cd, .stop_request, .digital_input_n,
    .virtual_command_bit, .stop_done);

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
    #1;
  endtask

  task rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task set_cause(input logic v);
    @(posedge sys_clk);
    cause <= v;
  endtask

  task manual;
    @(posedge sys_clk);
    manual_reset <= 1'b1;
    @(posedge sys_clk);
    manual_reset <= 1'b0;
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    tick(5000);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_reg(ADDR_CONFIG, 32'h400);
    rd_reg(8'h20, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      check(fan_runtime_clear, 3'h0);
      wr_reg(ADDR_FAN_CMD, 32'h1 << i);
      check(fan_runtime_clear, 3'h1 << i);
      tick(1);
      check(fan_runtime_clear, 3'h0);
    end
    // Unassigned source and auto off: response and window must hold
    wr_reg(ADDR_CONFIG, 32'h8000);
    rd_reg(ADDR_CONFIG, 32'h400);
    wr_reg(ADDR_IRQ_ENABLE, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      r = i[2:0];
      f = (r == 3'h1 || r == 3'h3 || r == 3'h4);
      // Park the source first so a polarity swap cannot fake an error
      wr_reg(ADDR_CONFIG, 32'h0);
      active_high <= r[0];
      via_cd <= (r == 3'h4);
      wr_reg(ADDR_CONFIG, (r == 3'h4 ? 32'h142 : {29'h0, r[0], 2'h1} | 32'h10) | {r, 10'h0});
      set_cause(1'b1);
      tick(2);
      check(ext_error_fault, r == 3'h1);
      check(ext_error_warning, r == 3'h0 || r == 3'h2);
      check(stop_request, (r < 3'h2) ? 3'h0 : {1'b1, r == 3'h2 ? 2'h0 : r[1:0] - 2'h2});
      tick(10);
      check(ext_error_fault, f);
      check(motor_drive_enable, !f);
      check(fault_state_out, f);
      check(irq, r != 3'h0);
      set_cause(1'b0);
      tick(3);
      manual();
      tick(3);
      check({ext_error_fault, ext_error_warning, motor_drive_enable}, 3'h1);
    end
    rd_reg(ADDR_IRQ_STATUS, 32'h3);
    wr_reg(ADDR_IRQ_CLEAR, 32'h3);
    tick(2);
    check(irq, 1'b0);
    rd_reg(ADDR_IRQ_STATUS, 32'h0);
    // Auto reset, low active input, five minute window
    active_high <= 1'b0;
    via_cd <= 1'b0;
    wr_reg(ADDR_CONFIG, 32'h2411);
    rd_reg(ADDR_CONFIG, 32'h2411);
    set_cause(1'b1);
    tick(3);
    check({ext_error_fault, fault_state_out}, 2'h2);
    set_cause(1'b0);
    tick(3);
    check({ext_error_fault, motor_drive_enable}, 2'h1);
    rd_reg(ADDR_IRQ_STATUS, 32'h5);
    set_cause(1'b1);
    tick(WIN_5_MIN * SEC_PER_MIN * 4);
    check({ext_error_fault, fault_state_out}, 2'h2);
    tick(1);
    check(fault_state_out, 1'b1);
    set_cause(1'b0);
    tick(5);
    check(ext_error_fault, 1'b1);
    manual();
    tick(3);
    check({ext_error_fault, fault_state_out, motor_drive_enable}, 3'h1);
    finish_test();
  end
endmodule
